// ---- core/vcmsr_pkg.sv ----
package vcmsr_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [11:0] IDX_EXT_FEATURE_ENABLE  = 12'h080;
	localparam logic [11:0] IDX_PRIMARY_EXEC_CAP    = 12'h482;
	localparam logic [11:0] IDX_EXIT_CTL_CAP        = 12'h483;
	localparam logic [11:0] IDX_ENTRY_CTL_CAP       = 12'h484;
	localparam logic [11:0] IDX_MISC_VIRT_CAP       = 12'h485;
	localparam logic [11:0] IDX_CTRL0_FIXED_ZERO    = 12'h486;
	localparam logic [11:0] IDX_CTRL0_FIXED_ONE     = 12'h487;
	localparam logic [11:0] IDX_CTRL4_FIXED_ZERO    = 12'h488;
	localparam logic [11:0] IDX_CTRL4_FIXED_ONE     = 12'h489;
	localparam logic [11:0] IDX_GUEST_FIELD_ENUM    = 12'h48a;
	localparam logic [11:0] IDX_SECONDARY_EXEC_CAP  = 12'h48b;
	localparam logic [11:0] IDX_DEBUG_STORE_BASE    = 12'h600;

	// Window select: each 64-bit register is two 32-bit words
	localparam logic [15:0] HALF_SELECT_OFFSET      = 16'h2000;
	localparam int          HALF_SELECT_BIT         = 13;

	localparam int          EXEC_DISABLE_BIT        = 11;
	localparam int          VIRT_FEATURE_BIT        = 9;
	localparam int          SECONDARY_PRESENT_BIT   = 63;
	localparam logic [31:0] DS_BASE_RESET           = 32'h0000_0000;
	localparam logic        EXEC_DISABLE_RESET      = 1'b0;
	localparam logic [31:0] UNMAPPED_READ_VALUE     = 32'h0000_0000;

	typedef struct packed {
		logic [63:0] primary_exec;
		logic [63:0] exit_ctl;
		logic [63:0] entry_ctl;
		logic [63:0] misc_virt;
		logic [63:0] ctrl0_fixed_zero;
		logic [63:0] ctrl0_fixed_one;
		logic [63:0] ctrl4_fixed_zero;
		logic [63:0] ctrl4_fixed_one;
		logic [63:0] guest_field_enum;
		logic [63:0] secondary_exec;
	} vcmsr_caps_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} vcmsr_apb_req_type;

endpackage : vcmsr_pkg

// ---- core/vcmsr_bank.sv ----
`timescale 1ns/1ns
// Behaviour
// - Read-only primary execution control capability at index 482H.
// - Read-only exit control capability at index 483H.
// - Read-only entry control capability at index 484H.
// - Read-only miscellaneous virtualization capability at index 485H.
// - Read-only control register zero fixed-to-0 report at 486H.
// - Read-only control register zero fixed-to-1 report at 487H.
// - Read-only control register four fixed-to-0 report at 488H.
// - Read-only control register four fixed-to-1 report at 489H.
// - Read-only guest control structure field enumeration at 48AH.
// - Read-only secondary execution control capability at 48BH.
// - Virtualization registers exist only when identification feature bit 9 set.
// - Secondary capability exists only when primary capability bit 63 set.
// - Debug-store base read/write; bits 31:0 address, 63:32 reserved zero.
// - Extended feature enable: bit 11 execute-disable, other bits reserved.
module vcmsr_bank
	import vcmsr_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              reset_n_i,
	input  wire vcmsr_apb_req_type apb_req_i,
	input  wire logic [31:0]       ident_feature_ecx_i,
	input  wire vcmsr_caps_type    caps_i,
	output logic                   pready_o,
	output logic                   pslverr_o,
	output logic [31:0]            prdata_o,
	output logic                   exec_disable_en_o,
	output logic [31:0]            ds_area_base_o
);

	////////////////////////////////////////////////////////////////////////////////
	// One-hot phases so that a corrupted code falls to the default arm
	typedef enum logic [2:0] {
		PHASE_IDLE   = 3'b001,
		PHASE_SETUP  = 3'b010,
		PHASE_ACCESS = 3'b100
	} vcmsr_phase_type;

	// One-hot answer class picked in the setup cycle
	typedef enum logic [2:0] {
		RESP_OKAY      = 3'b001,
		RESP_ABSENT    = 3'b010,
		RESP_READ_ONLY = 3'b100
	} vcmsr_resp_type;

	// What the setup cycle learned; the access phase acts on this copy
	typedef struct packed {
		logic [11:0] idx;
		logic        upper;
		logic        present;
		logic        writable;
		logic        write;
	} vcmsr_capture_type;

	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] ds_base_reg;
	logic [31:0] ds_base_next;
	logic        nxe_reg;
	logic        nxe_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	vcmsr_resp_type    resp_reg;
	vcmsr_resp_type    resp_next;
	vcmsr_resp_type    resp_now;
	vcmsr_phase_type   phase_reg;
	vcmsr_phase_type   phase_next;
	vcmsr_capture_type cap_reg;
	vcmsr_capture_type cap_next;
	logic        virt_on;
	logic        sec_on;
	logic [11:0] idx;
	logic        hi;
	logic [63:0] word64;
	logic        hit;
	logic        writable;
	logic        xfer;
	logic        setup_cyc;
	logic        access_ok;
	logic        store_we;
	logic        ds_we;
	logic        nxe_we;

	// Split a 64-bit register into the addressed word
	function automatic logic [31:0] half_of(input logic [63:0] v, input logic upper);
		half_of = upper ? v[63:32] : v[31:0];
	endfunction : half_of

	// Refusals: absent index first, then a write to a read-only one
	function automatic vcmsr_resp_type classify(input logic present, input logic wr, input logic can_write);
		if (!present) begin
			classify = RESP_ABSENT;
		end else if (wr && !can_write) begin
			classify = RESP_READ_ONLY;
		end else begin
			classify = RESP_OKAY;
		end
	endfunction : classify

	// Bit 13 picks the word, so the index stops below it
	assign idx     = {1'b0, apb_req_i.paddr[HALF_SELECT_BIT - 1:2]};
	assign hi      = apb_req_i.paddr[HALF_SELECT_BIT];
	assign virt_on = ident_feature_ecx_i[VIRT_FEATURE_BIT];
	assign sec_on  = virt_on && caps_i.primary_exec[SECONDARY_PRESENT_BIT];
	assign xfer    = apb_req_i.psel && apb_req_i.penable;
	assign setup_cyc = apb_req_i.psel && !apb_req_i.penable;

	////////////////////////////////////////////////////////////////////////////////
	// Index decode; absent registers answer with an error like a fault
	always_comb begin
		word64   = 64'h0;
		hit      = 1'b0;
		writable = 1'b0;
		unique case (idx)
			IDX_PRIMARY_EXEC_CAP: begin
				word64 = caps_i.primary_exec;
				hit    = virt_on;
			end
			IDX_EXIT_CTL_CAP: begin
				word64 = caps_i.exit_ctl;
				hit    = virt_on;
			end
			IDX_ENTRY_CTL_CAP: begin
				word64 = caps_i.entry_ctl;
				hit    = virt_on;
			end
			IDX_MISC_VIRT_CAP: begin
				word64 = caps_i.misc_virt;
				hit    = virt_on;
			end
			IDX_CTRL0_FIXED_ZERO: begin
				word64 = caps_i.ctrl0_fixed_zero;
				hit    = virt_on;
			end
			IDX_CTRL0_FIXED_ONE: begin
				word64 = caps_i.ctrl0_fixed_one;
				hit    = virt_on;
			end
			IDX_CTRL4_FIXED_ZERO: begin
				word64 = caps_i.ctrl4_fixed_zero;
				hit    = virt_on;
			end
			IDX_CTRL4_FIXED_ONE: begin
				word64 = caps_i.ctrl4_fixed_one;
				hit    = virt_on;
			end
			IDX_GUEST_FIELD_ENUM: begin
				word64 = caps_i.guest_field_enum;
				hit    = virt_on;
			end
			IDX_SECONDARY_EXEC_CAP: begin
				word64 = caps_i.secondary_exec;
				hit    = sec_on;
			end
			IDX_DEBUG_STORE_BASE: begin
				word64   = {32'h0, ds_base_reg};
				hit      = 1'b1;
				writable = 1'b1;
			end
			IDX_EXT_FEATURE_ENABLE: begin
				word64   = {52'h0, nxe_reg, 11'h0};
				hit      = 1'b1;
				writable = 1'b1;
			end
			default: begin
				word64 = 64'h0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Setup cycle latches the answer so the access phase always ends in one cycle
	assign resp_now = classify(hit, apb_req_i.pwrite, writable);

	always_comb begin
		cap_next   = cap_reg;
		rdata_next = rdata_reg;
		resp_next  = resp_reg;
		if (setup_cyc) begin
			cap_next.idx      = idx;
			cap_next.upper    = hi;
			cap_next.present  = hit;
			cap_next.writable = writable;
			cap_next.write    = apb_req_i.pwrite;
			rdata_next        = hit ? half_of(word64, hi) : UNMAPPED_READ_VALUE;
			resp_next         = resp_now;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cap_reg   <= '0;
			rdata_reg <= UNMAPPED_READ_VALUE;
			resp_reg  <= RESP_OKAY;
		end else begin
			cap_reg   <= cap_next;
			rdata_reg <= rdata_next;
			resp_reg  <= resp_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase tracker; an access phase with no setup before it writes nothing
	always_comb begin
		phase_next = phase_reg;
		unique case (phase_reg)
			PHASE_IDLE: begin
				if (setup_cyc) begin
					phase_next = PHASE_SETUP;
				end
			end
			PHASE_SETUP: begin
				if (xfer) begin
					phase_next = PHASE_ACCESS;
				end else if (setup_cyc) begin
					phase_next = PHASE_SETUP;
				end else begin
					phase_next = PHASE_IDLE;
				end
			end
			PHASE_ACCESS: begin
				// No wait states, so the access always ends at its first edge
				if (setup_cyc) begin
					phase_next = PHASE_SETUP;
				end else begin
					phase_next = PHASE_IDLE;
				end
			end
			default: begin
				phase_next = PHASE_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_reg <= PHASE_IDLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Writes act on the captured index, so a drifting address cannot retarget them
	assign access_ok = xfer && (phase_reg == PHASE_SETUP);
	assign store_we  = access_ok && cap_reg.write && cap_reg.present && cap_reg.writable && !cap_reg.upper;
	assign ds_we     = store_we && (cap_reg.idx == IDX_DEBUG_STORE_BASE);
	assign nxe_we    = store_we && (cap_reg.idx == IDX_EXT_FEATURE_ENABLE);

	always_comb begin
		ds_base_next = ds_base_reg;
		nxe_next     = nxe_reg;
		// Upper words are reserved; writes there change nothing
		if (ds_we) begin
			ds_base_next = apb_req_i.pwdata;
		end
		if (nxe_we) begin
			nxe_next = apb_req_i.pwdata[EXEC_DISABLE_BIT];
		end
	end

	// Per-instance state only; a multi-core chip places one bank per core
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ds_base_reg <= DS_BASE_RESET;
			nxe_reg     <= EXEC_DISABLE_RESET;
		end else begin
			ds_base_reg <= ds_base_next;
			nxe_reg     <= nxe_next;
		end
	end

	assign pready_o          = 1'b1;
	assign pslverr_o         = xfer && (resp_reg != RESP_OKAY);
	assign prdata_o          = rdata_reg;
	assign exec_disable_en_o = nxe_reg;
	assign ds_area_base_o    = ds_base_reg;

endmodule : vcmsr_bank

// ---- verif/vcmsr_bank_checker.sv ----
`timescale 1ns/1ns
module vcmsr_bank_checker
	import vcmsr_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              reset_n_i,
	input  wire vcmsr_apb_req_type apb_req_i,
	input  wire logic [31:0]       ident_feature_ecx_i,
	input  wire vcmsr_caps_type    caps_i,
	input  wire logic              pready_o,
	input  wire logic              pslverr_o,
	input  wire logic [31:0]       prdata_o,
	input  wire logic              exec_disable_en_o,
	input  wire logic [31:0]       ds_area_base_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	vcmsr_apb_req_type p;
	logic              s;
	logic              w;
	assign p = apb_req_i;
	assign s = p.psel & !p.penable;
	assign w = p.psel & p.penable & p.pwrite;
	////////////////////////////////////////////////////////////
	a_ds_write: assert property (w && p.paddr == 16'h1800 |=>
		ds_area_base_o == $past(p.pwdata)) else $error("ds base write lost");
	a_ds_hold: assert property (!(w && p.paddr == 16'h1800) |=> $stable(ds_area_base_o))
		else $error("ds base changed");
	a_xd_write: assert property (w && p.paddr == 16'h0200 |=>
		exec_disable_en_o == $past(p.pwdata[11])) else $error("xd bit wrong");
	a_ds_upper: assert property (s && p.paddr == 16'h3800 |=> prdata_o == 32'h0)
		else $error("ds upper not zero");
	a_novirt_err: assert property (s && p.paddr == 16'h1208 && !ident_feature_ecx_i[9] ##1 p.penable
		|-> pslverr_o && prdata_o == 32'h0) else $error("absent reg answered");
	a_cap_read: assert property (s && p.paddr == 16'h1208 && ident_feature_ecx_i[9] |=>
		prdata_o == $past(caps_i.primary_exec[31:0])) else $error("cap read wrong");
	a_sec_gate: assert property (s && p.paddr == 16'h122c && !caps_i.primary_exec[63] |=>
		prdata_o == 32'h0) else $error("secondary not gated");
	a_ro_write: assert property (s && p.pwrite && p.paddr == 16'h1214 ##1 p.penable |-> pslverr_o)
		else $error("ro write accepted");
	cover property (w && p.paddr == 16'h1800);
	cover property (s && p.paddr == 16'h122c);
	cover property (pslverr_o);
endmodule : vcmsr_bank_checker
bind vcmsr_bank vcmsr_bank_checker u_vcmsr_bank_checker (.*);

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb
	import vcmsr_pkg::*;
;
	logic              clk = 0;
	logic              rst_n = 0;
	vcmsr_apb_req_type req = '0;
	logic [31:0]       ecx = 32'h0000_0200;
	vcmsr_caps_type    caps;
	logic              rdy, perr, xd, err;
	logic [31:0]       prd, ds, rd;
	int                num_errors = 0, checks = 0, cyc = 0;
	always #4 clk = ~clk;
	vcmsr_bank u_vcmsr_bank (.ref_clk_i(clk), .reset_n_i(rst_n), .apb_req_i(req), .ident_feature_ecx_i(ecx),
		.caps_i(caps), .pready_o(rdy), .pslverr_o(perr), .prdata_o(prd), .exec_disable_en_o(xd), .ds_area_base_o(ds));
	////////////////////////////////////////////////////////////
	task results;
		if (num_errors == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task chk(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Sampled at the completing edge, before that edge's updates land
	task apb(logic wr, logic [15:0] a, logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = prd;
		err = perr;
		req <= '0;
	endtask : apb
	task t_caps;
		for (int i = 0; i < 10; i++) begin
			apb(0, 16'({12'h482 + 12'(i), 2'b00}), 0);
			chk("cap lo", 32'h1234_0000 | i, rd);
			apb(0, 16'({12'h482 + 12'(i), 2'b00}) | 16'h2000, 0);
			chk("cap hi", 32'h8000_0000 | i, rd);
		end
	endtask : t_caps
	task t_gate;
		ecx <= '0;
		apb(0, 16'h1208, 0);
		chk("novirt", 1, 32'(err));
		ecx <= 32'h0000_0200;
		caps.primary_exec[63] <= 1'b0;
		apb(0, 16'h122c, 0);
		chk("nosec", 1, 32'(err));
		caps.primary_exec[63] <= 1'b1;
		apb(1, 16'h1214, 32'hffff_ffff);
		chk("ro wr", 1, 32'(err));
		apb(0, 16'h1214, 0);
		chk("ro keep", 32'h1234_0003, rd);
		apb(0, 16'h0ff0, 0);
		chk("unmapped", 1, 32'(err));
	endtask : t_gate
	task t_rw;
		chk("ds rst", 0, ds);
		chk("xd rst", 0, 32'(xd));
		apb(1, 16'h1800, 32'hdead_beef);
		apb(0, 16'h1800, 0);
		chk("ds rd", 32'hdead_beef, rd);
		chk("ds out", 32'hdead_beef, ds);
		apb(1, 16'h3800, 32'hffff_ffff);
		apb(0, 16'h3800, 0);
		chk("ds hi", 0, rd);
		apb(1, 16'h0200, 32'hffff_ffff);
		apb(0, 16'h0200, 0);
		chk("efer", 32'h0000_0800, rd);
		chk("xd set", 1, 32'(xd));
		apb(1, 16'h0200, 32'hffff_f7ff);
		// The write lands at the completing edge; look one edge later
		@(posedge clk);
		chk("xd clr", 0, 32'(xd));
	endtask : t_rw
	////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		for (int i = 0; i < 10; i++) caps[(9 - i) * 64 +: 64] = {32'h8000_0000 | i, 32'h1234_0000 | i};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_rw();
		t_caps();
		t_gate();
		results();
	end
endmodule : tb
